// ---- rtl/rcl_pkg.sv ----
package rcl_pkg;
    // serial word layout: 14 data bits above a 2-bit address
    localparam int WORD_W        = 16;
    localparam int ADDR_W        = 2;
    localparam int BIT_CNT_W     = 5;
    localparam logic [1:0] ADDR_CONFIG  = 2'h0;
    localparam logic [1:0] ADDR_CHANNEL = 2'h1;
    localparam logic [1:0] ADDR_TEST    = 2'h2;

    // channel frequency word
    localparam int CH_INT_LSB    = 6;
    localparam int CH_INT_W      = 10;
    localparam int CH_FRAC_LSB   = 2;
    localparam int CH_FRAC_W     = 4;
    localparam logic [3:0] CH_FRAC_MAX = 4'h8;
    localparam logic [9:0] CH_INT_RESET  = 10'h000;
    localparam logic [3:0] CH_FRAC_RESET = 4'h0;

    // test mode access word
    localparam int TM_OVR_BIT    = 15;
    localparam int TM_CODE_LSB   = 8;
    localparam int TM_CODE_W     = 7;
    localparam int TM_DSEL_LSB   = 5;
    localparam int TM_ASEL_LSB   = 2;
    localparam int TM_SEL_W      = 3;
    localparam logic [2:0] TM_SEL_RESET  = 3'h0;
    localparam logic [6:0] TM_CODE_RESET = 7'h00;

    // configuration word, only the analog-output mode bit is kept here
    localparam int CFG_ANALOG_OUTPUT_PIN_BIT  = 4;

    // host serial timing
    localparam int CLK_MHZ       = 125;
    localparam int SCLK_HALF_NS  = 80;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam int HALF_CNT_W    = 16;

    // host register map
    localparam logic [3:0] HREG_SEND   = 4'h0;
    localparam logic [3:0] HREG_STATUS = 4'h4;
    localparam logic [3:0] HREG_HALF   = 4'h8;
    localparam int ST_BUSY_BIT   = 0;
    localparam int ST_REJECT_BIT = 1;
    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// ---- rtl/rcl_link_if.sv ----
`timescale 1ns/1ps
interface rcl_link_if;
    logic sclk;
    logic sdata;
    logic slatch;
    modport host   (output sclk, output sdata, output slatch);
    modport device (input sclk, input sdata, input slatch);
endinterface

// ---- rtl/rcl_device.sv ----
`timescale 1ns/1ps
module rcl_device
    import rcl_pkg::*;
(
    input  wire logic          CLK_SYS_IN,
    input  wire logic          RST_B_IN,
    rcl_link_if.device         SER_LINK,
    input  wire logic          RX_SLOT_IN,
    input  wire logic [6:0]    AUTO_TUNE_CODE_IN,
    input  wire logic          PA_CTRL_IN,
    input  wire logic          RX_DATA_IN,
    input  wire logic          AGC_SWITCH_IN,
    input  wire logic          PRESCALE_DIV64_IN,
    input  wire logic          MAIN_DIV_IN,
    input  wire logic          REF_DIV_IN,
    input  wire logic          CARRY2_IN,
    input  wire logic          CARRY1_IN,
    input  wire logic          CALIBRATION_TIMER_IN,
    input  wire logic          CLK_3MHZ_IN,
    input  wire logic          PLL_LOCK_LOW_IN,
    input  wire logic          UPDATE_LATCH_IN,
    output logic [9:0]         CHAN_INT_CODE_OUT,
    output logic [10:0]        CHAN_INT_RATIO_OUT,
    output logic [3:0]         CHAN_FRAC_CODE_OUT,
    output logic               ALIGNMENT_OVERRIDE_OUT,
    output logic [6:0]         FILTER_TUNE_CODE_OUT,
    output logic [6:0]         FILTER_CODE_APPLIED_OUT,
    output logic               AUTO_ALIGN_RUN_OUT,
    output logic [2:0]         ANALOG_PROBE_SELECT_OUT,
    output logic [2:0]         DIGITAL_PROBE_SELECT_OUT,
    output logic [7:0]         ANALOG_ROUTE_OUT,
    output logic               ANALOG_OUT_DATA_MODE_OUT,
    output logic               PA_ENABLE_PIN_OUT,
    output logic               DATA_PIN_OUT
);
    // three-stage sampling of the slow serial lines
    logic [2:0]         s1_q;
    logic [2:0]         s2_q;
    logic [2:0]         s3_q;
    logic [2:0]         filt_q;
    logic [2:0]         filt_d;
    logic [WORD_W-1:0]  shift_q;
    logic [BIT_CNT_W-1:0] cnt_q;
    logic [9:0]         int_q;
    logic [3:0]         frac_q;
    logic               ovr_q;
    logic [6:0]         code_q;
    logic [2:0]         dsel_q;
    logic [2:0]         asel_q;
    logic               analog_output_pin_mode_q;

    // bit 0 sclk, bit 1 sdata, bit 2 slatch; a change counts once stages two and three agree
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
        end
    end

    wire sclk_rise  = filt_d[0] & ~filt_q[0];
    wire latch_rise = filt_d[2] & ~filt_q[2];
    wire word_full  = (cnt_q >= BIT_CNT_W'(WORD_W));
    wire [WORD_W-1:0] word = shift_q;
    wire [1:0] waddr      = word[ADDR_W-1:0];
    wire [3:0] new_frac   = word[CH_FRAC_LSB +: CH_FRAC_W];
    // a latch before sixteen bits discards the partial word
    wire commit       = latch_rise & word_full;
    wire wr_channel   = commit & (waddr == ADDR_CHANNEL) & (new_frac <= CH_FRAC_MAX);
    wire wr_test      = commit & (waddr == ADDR_TEST);
    wire wr_config    = commit & (waddr == ADDR_CONFIG);

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_B_IN) begin
            s1_q   <= 3'h0;
            s2_q   <= 3'h0;
            s3_q   <= 3'h0;
            filt_q <= 3'h0;
        end else begin
            s1_q   <= {SER_LINK.slatch, SER_LINK.sdata, SER_LINK.sclk};
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            filt_q <= filt_d;
        end
    end

    // shifter, first bit received ends up in B15
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_B_IN) begin
            shift_q <= 16'h0000;
            cnt_q   <= 5'h00;
        end else if (latch_rise) begin
            cnt_q   <= 5'h00;
        end else if (sclk_rise) begin
            shift_q <= {shift_q[WORD_W-2:0], filt_q[1]};
            cnt_q   <= word_full ? cnt_q : cnt_q + 5'h01;
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_B_IN) begin
            int_q       <= CH_INT_RESET;
            frac_q      <= CH_FRAC_RESET;
            ovr_q       <= 1'b0;
            code_q      <= TM_CODE_RESET;
            dsel_q      <= TM_SEL_RESET;
            asel_q      <= TM_SEL_RESET;
            analog_output_pin_mode_q <= 1'b0;
        end else begin
            if (wr_channel) begin
                int_q  <= word[CH_INT_LSB +: CH_INT_W];
                frac_q <= new_frac;
            end
            if (wr_test) begin
                ovr_q  <= word[TM_OVR_BIT];
                code_q <= word[TM_CODE_LSB +: TM_CODE_W];
                dsel_q <= word[TM_DSEL_LSB +: TM_SEL_W];
                asel_q <= word[TM_ASEL_LSB +: TM_SEL_W];
            end
            if (wr_config) begin
                analog_output_pin_mode_q <= word[CFG_ANALOG_OUTPUT_PIN_BIT];
            end
        end
    end

    // digital probe selection for the PA and data pins
    logic pa_sel;
    logic data_sel;
    always_comb begin
        case (dsel_q)
            3'h0: begin pa_sel = PA_CTRL_IN;        data_sel = RX_DATA_IN;           end
            3'h1: begin pa_sel = 1'b0;              data_sel = AGC_SWITCH_IN;        end
            3'h2: begin pa_sel = PRESCALE_DIV64_IN; data_sel = MAIN_DIV_IN;          end
            3'h3: begin pa_sel = 1'b0;              data_sel = REF_DIV_IN;           end
            3'h4: begin pa_sel = CARRY2_IN;         data_sel = CARRY1_IN;            end
            3'h5: begin pa_sel = 1'b0;              data_sel = CALIBRATION_TIMER_IN; end
            3'h6: begin pa_sel = CLK_3MHZ_IN;       data_sel = PLL_LOCK_LOW_IN;      end
            3'h7: begin pa_sel = 1'b0;              data_sel = UPDATE_LATCH_IN;      end
            default: begin pa_sel = PA_CTRL_IN;     data_sel = RX_DATA_IN;           end
        endcase
    end

    // one-hot analog routing, bit 0 is the normal pin function
    wire [7:0] route_sel   = 8'h01 << asel_q;
    wire       analog_output_pin_data   = (asel_q == 3'h0) & analog_output_pin_mode_q;
    wire [6:0] applied     = ovr_q ? code_q : AUTO_TUNE_CODE_IN;
    wire       align_run   = RX_SLOT_IN & ~ovr_q;
    // fixed implied top bit; the synthesizer turns ratio and fraction into frequency
    wire [10:0] int_ratio  = {1'b1, int_q};

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_B_IN) begin
            CHAN_INT_CODE_OUT        <= CH_INT_RESET;
            CHAN_INT_RATIO_OUT       <= 11'h400;
            CHAN_FRAC_CODE_OUT       <= CH_FRAC_RESET;
            ALIGNMENT_OVERRIDE_OUT   <= 1'b0;
            FILTER_TUNE_CODE_OUT     <= TM_CODE_RESET;
            FILTER_CODE_APPLIED_OUT  <= TM_CODE_RESET;
            AUTO_ALIGN_RUN_OUT       <= 1'b0;
            ANALOG_PROBE_SELECT_OUT  <= TM_SEL_RESET;
            DIGITAL_PROBE_SELECT_OUT <= TM_SEL_RESET;
            ANALOG_ROUTE_OUT         <= 8'h01;
            ANALOG_OUT_DATA_MODE_OUT <= 1'b0;
            PA_ENABLE_PIN_OUT        <= 1'b0;
            DATA_PIN_OUT             <= 1'b0;
        end else begin
            CHAN_INT_CODE_OUT        <= int_q;
            CHAN_INT_RATIO_OUT       <= int_ratio;
            CHAN_FRAC_CODE_OUT       <= frac_q;
            ALIGNMENT_OVERRIDE_OUT   <= ovr_q;
            FILTER_TUNE_CODE_OUT     <= code_q;
            FILTER_CODE_APPLIED_OUT  <= applied;
            AUTO_ALIGN_RUN_OUT       <= align_run;
            ANALOG_PROBE_SELECT_OUT  <= asel_q;
            DIGITAL_PROBE_SELECT_OUT <= dsel_q;
            ANALOG_ROUTE_OUT         <= route_sel;
            ANALOG_OUT_DATA_MODE_OUT <= analog_output_pin_data;
            PA_ENABLE_PIN_OUT        <= pa_sel;
            DATA_PIN_OUT             <= data_sel;
        end
    end
endmodule

// ---- rtl/rcl_host.sv ----
`timescale 1ns/1ps
module rcl_host
    import rcl_pkg::*;
(
    input  wire logic          CLK_SYS_IN,
    input  wire logic          RST_B_IN,
    input  wire logic [3:0]    AXI_AWADDR_IN,
    input  wire logic          AXI_AWVALID_IN,
    output logic               AXI_AWREADY_OUT,
    input  wire logic [31:0]   AXI_WDATA_IN,
    input  wire logic [3:0]    AXI_WSTRB_IN,
    input  wire logic          AXI_WVALID_IN,
    output logic               AXI_WREADY_OUT,
    output logic [1:0]         AXI_BRESP_OUT,
    output logic               AXI_BVALID_OUT,
    input  wire logic          AXI_BREADY_IN,
    input  wire logic [3:0]    AXI_ARADDR_IN,
    input  wire logic          AXI_ARVALID_IN,
    output logic               AXI_ARREADY_OUT,
    output logic [31:0]        AXI_RDATA_OUT,
    output logic [1:0]         AXI_RRESP_OUT,
    output logic               AXI_RVALID_OUT,
    input  wire logic          AXI_RREADY_IN,
    rcl_link_if.host           SER_LINK
);
    typedef enum logic [2:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_LATCH, ST_GAP} rcl_state_type;

    rcl_state_type      st_q;
    logic [3:0]         awaddr_q;
    logic               aw_have_q;
    logic [31:0]        wdata_q;
    logic [3:0]         wstrb_q;
    logic               w_have_q;
    logic [HALF_CNT_W-1:0] half_q;
    logic [HALF_CNT_W-1:0] tmr_q;
    logic [WORD_W-1:0]  shift_q;
    logic [BIT_CNT_W-1:0] bits_q;
    logic               reject_q;
    logic               sclk_q;
    logic               sdata_q;
    logic               slatch_q;

    assign SER_LINK.sclk   = sclk_q;
    assign SER_LINK.sdata  = sdata_q;
    assign SER_LINK.slatch = slatch_q;

    wire        do_write   = aw_have_q & w_have_q & ~AXI_BVALID_OUT;
    wire        busy       = (st_q != ST_IDLE);
    wire        hit_send   = (awaddr_q == HREG_SEND);
    wire        hit_half   = (awaddr_q == HREG_HALF);
    wire        wr_ok      = hit_send | hit_half | (awaddr_q == HREG_STATUS);
    wire [15:0] word_in    = wdata_q[15:0];
    // channel words with a fraction code above eight are never sent
    wire        bad_frac   = (word_in[ADDR_W-1:0] == ADDR_CHANNEL) &
                             (word_in[CH_FRAC_LSB +: CH_FRAC_W] > CH_FRAC_MAX);
    wire        send_req   = do_write & hit_send & (wstrb_q[1:0] == 2'h3);
    wire        start      = send_req & ~busy & ~bad_frac;
    wire        refuse     = send_req & (busy | bad_frac);
    wire        tick       = (tmr_q == 16'h0000);
    wire [15:0] half_wr    = {wstrb_q[1] ? wdata_q[15:8] : half_q[15:8],
                              wstrb_q[0] ? wdata_q[7:0]  : half_q[7:0]};
    wire [15:0] half_new   = (half_wr == 16'h0000) ? 16'h0001 : half_wr;
    wire        rd_take    = AXI_ARVALID_IN & AXI_ARREADY_OUT;
    wire        rd_known   = (AXI_ARADDR_IN == HREG_SEND) | (AXI_ARADDR_IN == HREG_STATUS) |
                             (AXI_ARADDR_IN == HREG_HALF);
    wire [31:0] rd_val     = (AXI_ARADDR_IN == HREG_STATUS) ? {30'h0, reject_q, busy} :
                             (AXI_ARADDR_IN == HREG_HALF)   ? {16'h0, half_q} : 32'h0;

    // write channels, taken in either order
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_B_IN) begin
            AXI_AWREADY_OUT <= 1'b1;
            AXI_WREADY_OUT  <= 1'b1;
            aw_have_q       <= 1'b0;
            w_have_q        <= 1'b0;
            awaddr_q        <= 4'h0;
            wdata_q         <= 32'h0;
            wstrb_q         <= 4'h0;
            AXI_BVALID_OUT  <= 1'b0;
            AXI_BRESP_OUT   <= AXI_OKAY;
        end else begin
            if (AXI_AWVALID_IN & AXI_AWREADY_OUT) begin
                awaddr_q        <= AXI_AWADDR_IN;
                aw_have_q       <= 1'b1;
                AXI_AWREADY_OUT <= 1'b0;
            end
            if (AXI_WVALID_IN & AXI_WREADY_OUT) begin
                wdata_q        <= AXI_WDATA_IN;
                wstrb_q        <= AXI_WSTRB_IN;
                w_have_q       <= 1'b1;
                AXI_WREADY_OUT <= 1'b0;
            end
            if (do_write) begin
                aw_have_q      <= 1'b0;
                w_have_q       <= 1'b0;
                AXI_BVALID_OUT <= 1'b1;
                AXI_BRESP_OUT  <= wr_ok ? AXI_OKAY : AXI_SLVERR;
            end
            if (AXI_BVALID_OUT & AXI_BREADY_IN) begin
                AXI_BVALID_OUT  <= 1'b0;
                AXI_AWREADY_OUT <= 1'b1;
                AXI_WREADY_OUT  <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_B_IN) begin
            AXI_ARREADY_OUT <= 1'b1;
            AXI_RVALID_OUT  <= 1'b0;
            AXI_RDATA_OUT   <= 32'h0;
            AXI_RRESP_OUT   <= AXI_OKAY;
        end else if (rd_take) begin
            AXI_ARREADY_OUT <= 1'b0;
            AXI_RVALID_OUT  <= 1'b1;
            AXI_RDATA_OUT   <= rd_val;
            AXI_RRESP_OUT   <= rd_known ? AXI_OKAY : AXI_SLVERR;
        end else if (AXI_RVALID_OUT & AXI_RREADY_IN) begin
            AXI_RVALID_OUT  <= 1'b0;
            AXI_ARREADY_OUT <= 1'b1;
        end
    end

    // serial engine: data set while clock low, device samples on clock rise
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_B_IN) begin
            st_q     <= ST_IDLE;
            half_q   <= 16'(SCLK_HALF_CYC);
            tmr_q    <= 16'h0000;
            shift_q  <= 16'h0000;
            bits_q   <= 5'h00;
            reject_q <= 1'b0;
            sclk_q   <= 1'b0;
            sdata_q  <= 1'b0;
            slatch_q <= 1'b0;
        end else begin
            if (do_write & hit_half) begin
                half_q <= half_new;
            end
            if (refuse) begin
                reject_q <= 1'b1;
            end else if (start) begin
                reject_q <= 1'b0;
            end
            tmr_q <= tick ? 16'h0000 : tmr_q - 16'h0001;
            case (st_q)
                ST_IDLE: begin
                    if (start) begin
                        shift_q <= {word_in[14:0], 1'b0};
                        sdata_q <= word_in[15];
                        bits_q  <= 5'h00;
                        tmr_q   <= half_q - 16'h0001;
                        st_q    <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    if (tick) begin
                        sclk_q <= 1'b1;
                        bits_q <= bits_q + 5'h01;
                        tmr_q  <= half_q - 16'h0001;
                        st_q   <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    if (tick) begin
                        sclk_q <= 1'b0;
                        tmr_q  <= half_q - 16'h0001;
                        if (bits_q == BIT_CNT_W'(WORD_W)) begin
                            slatch_q <= 1'b1;
                            st_q     <= ST_LATCH;
                        end else begin
                            sdata_q <= shift_q[WORD_W-1];
                            shift_q <= {shift_q[WORD_W-2:0], 1'b0};
                            st_q    <= ST_LOW;
                        end
                    end
                end
                ST_LATCH: begin
                    if (tick) begin
                        slatch_q <= 1'b0;
                        sdata_q  <= 1'b0;
                        tmr_q    <= half_q - 16'h0001;
                        st_q     <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (tick) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
endmodule

// ---- tb/rcl_props.sv ----
`timescale 1ns/1ps
module rcl_props
    import rcl_pkg::*;
(
    input wire logic        CLK_SYS_IN,
    input wire logic        RST_B_IN,
    input wire logic        sclk,
    input wire logic        sdata,
    input wire logic        slatch,
    input wire logic        RX_SLOT_IN,
    input wire logic [6:0]  AUTO_TUNE_CODE_IN,
    input wire logic [9:0]  CHAN_INT_CODE_OUT,
    input wire logic [10:0] CHAN_INT_RATIO_OUT,
    input wire logic [3:0]  CHAN_FRAC_CODE_OUT,
    input wire logic        ALIGNMENT_OVERRIDE_OUT,
    input wire logic [6:0]  FILTER_TUNE_CODE_OUT,
    input wire logic [6:0]  FILTER_CODE_APPLIED_OUT,
    input wire logic        AUTO_ALIGN_RUN_OUT,
    input wire logic [2:0]  ANALOG_PROBE_SELECT_OUT,
    input wire logic [7:0]  ANALOG_ROUTE_OUT,
    input wire logic        ANALOG_OUT_DATA_MODE_OUT
);
    // live_q skips the edges right after reset, where outputs still hold reset values
    logic [1:0] live_q;
    logic [1:0] live_d;
    logic [7:0] since_q;
    logic [7:0] since_d;
    assign live_d  = (live_q == 2'h3) ? live_q : live_q + 2'h1;
    assign since_d = slatch ? 8'h00 : ((since_q == 8'hff) ? since_q : since_q + 8'h01);
    always_ff @(posedge CLK_SYS_IN) begin
        live_q  <= RST_B_IN ? live_d : 2'h0;
        since_q <= RST_B_IN ? since_d : 8'hff;
    end
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_B_IN);

    a_ratio_top_one: assert property (CHAN_INT_RATIO_OUT == {1'b1, CHAN_INT_CODE_OUT})
        else $error("ratio lacks implied top bit");
    a_frac_legal: assert property (CHAN_FRAC_CODE_OUT <= CH_FRAC_MAX)
        else $error("fraction code above eight");
    a_route_one_hot: assert property ($stable(ANALOG_PROBE_SELECT_OUT) |->
        ANALOG_ROUTE_OUT == (8'h01 << ANALOG_PROBE_SELECT_OUT)) else $error("analog route mismatch");
    a_analog_output_pin_probe_mode: assert property ((ANALOG_PROBE_SELECT_OUT != 3'h0) |->
        !ANALOG_OUT_DATA_MODE_OUT) else $error("data mode while probing");
    a_applied_code: assert property ((live_q == 2'h3) && $stable(ALIGNMENT_OVERRIDE_OUT)
        && $stable(FILTER_TUNE_CODE_OUT) |-> FILTER_CODE_APPLIED_OUT ==
        (ALIGNMENT_OVERRIDE_OUT ? FILTER_TUNE_CODE_OUT : $past(AUTO_TUNE_CODE_IN)))
        else $error("applied filter code wrong");
    a_auto_run: assert property ((live_q == 2'h3) && $stable(ALIGNMENT_OVERRIDE_OUT) |->
        AUTO_ALIGN_RUN_OUT == ($past(RX_SLOT_IN) && !ALIGNMENT_OVERRIDE_OUT)) else $error("auto align run wrong");
    a_latch_clock_low: assert property (slatch |-> !sclk)
        else $error("clock high during latch");
    a_bit_stable: assert property (sclk |-> $stable(sdata))
        else $error("data moved while clock high");
    a_commit_latch: assert property (($changed(CHAN_INT_CODE_OUT) || $changed(FILTER_TUNE_CODE_OUT) ||
        $changed(ANALOG_PROBE_SELECT_OUT)) |-> since_q < 8'd12) else $error("register changed without latch");
endmodule

// ---- tb/radio_channel_and_test_regs_bench.sv ----
`timescale 1ns/1ps
module radio_channel_and_test_regs_bench;
    import rcl_pkg::*;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, rx_slot = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [11:0] s = 12'h0;
    logic [6:0]  auto_code = 7'h00;
    wire logic   awready, wready, bvalid, arready, rvalid, ovr, run, mode, pa, dat;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [9:0]  ncode;
    wire logic [10:0] ratio;
    wire logic [3:0]  frac;
    wire logic [6:0]  tune, applied;
    wire logic [2:0]  asel, dsel;
    wire logic [7:0]  route;
    int          fail_count = 0;
    int          compares = 0;
    always #4 clk = ~clk;
    rcl_link_if link ();
    rcl_host rcl_host_inst (.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid),
        .AXI_AWREADY_OUT(awready), .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(wstrb), .AXI_WVALID_IN(wvalid),
        .AXI_WREADY_OUT(wready), .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready),
        .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready), .AXI_RDATA_OUT(rdata),
        .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready), .SER_LINK(link));
    rcl_device rcl_device_inst (.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .SER_LINK(link), .RX_SLOT_IN(rx_slot),
        .AUTO_TUNE_CODE_IN(auto_code), .PA_CTRL_IN(s[0]), .RX_DATA_IN(s[1]), .AGC_SWITCH_IN(s[2]),
        .PRESCALE_DIV64_IN(s[3]), .MAIN_DIV_IN(s[4]), .REF_DIV_IN(s[5]), .CARRY2_IN(s[6]), .CARRY1_IN(s[7]),
        .CALIBRATION_TIMER_IN(s[8]), .CLK_3MHZ_IN(s[9]), .PLL_LOCK_LOW_IN(s[10]), .UPDATE_LATCH_IN(s[11]),
        .CHAN_INT_CODE_OUT(ncode), .CHAN_INT_RATIO_OUT(ratio), .CHAN_FRAC_CODE_OUT(frac),
        .ALIGNMENT_OVERRIDE_OUT(ovr), .FILTER_TUNE_CODE_OUT(tune), .FILTER_CODE_APPLIED_OUT(applied),
        .AUTO_ALIGN_RUN_OUT(run), .ANALOG_PROBE_SELECT_OUT(asel), .DIGITAL_PROBE_SELECT_OUT(dsel),
        .ANALOG_ROUTE_OUT(route), .ANALOG_OUT_DATA_MODE_OUT(mode), .PA_ENABLE_PIN_OUT(pa), .DATA_PIN_OUT(dat));
    rcl_props rcl_props_inst (.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .sclk(link.sclk), .sdata(link.sdata),
        .slatch(link.slatch), .RX_SLOT_IN(rx_slot), .AUTO_TUNE_CODE_IN(auto_code), .CHAN_INT_CODE_OUT(ncode),
        .CHAN_INT_RATIO_OUT(ratio), .CHAN_FRAC_CODE_OUT(frac), .ALIGNMENT_OVERRIDE_OUT(ovr),
        .FILTER_TUNE_CODE_OUT(tune), .FILTER_CODE_APPLIED_OUT(applied), .AUTO_ALIGN_RUN_OUT(run),
        .ANALOG_PROBE_SELECT_OUT(asel), .ANALOG_ROUTE_OUT(route), .ANALOG_OUT_DATA_MODE_OUT(mode));

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // wr and rd open with an edge so back-to-back calls never drive a signal twice in one step
    task wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hf; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task send(input logic [15:0] w);
        logic [31:0] d;
        logic [1:0]  r;
        wr(HREG_SEND, {16'h0, w}, r);
        do rd(HREG_STATUS, d, r); while (d[ST_BUSY_BIT]);
        repeat (8) @(posedge clk);
    endtask
    task close_out();
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [2:0]  c;
        logic [7:0]  pt, dt;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        chk("ratio", 32'h400, ratio);
        chk("asel", 32'h0, asel);
        chk("dsel", 32'h0, dsel);
        wr(HREG_HALF, 32'h4, r);
        chk("half bresp", AXI_OKAY, r);
        rd(HREG_HALF, d, r);
        chk("half", 32'h4, d[15:0]);
        rd(4'hc, d, r);
        chk("unmapped", AXI_SLVERR, r);
        send({10'h3fe, 4'h8, ADDR_CHANNEL});
        chk("ncode", 32'h3fe, ncode);
        chk("ratio", 32'h7fe, ratio);
        chk("frac", 32'h8, frac);
        send({10'h155, 4'h9, ADDR_CHANNEL});
        rd(HREG_STATUS, d, r);
        chk("reject", 32'h1, d[ST_REJECT_BIT]);
        chk("ncode", 32'h3fe, ncode);
        send({10'h2aa, 4'h3, 2'h3});
        chk("ncode", 32'h3fe, ncode);
        send({11'h0, 1'b1, 2'h0, ADDR_CONFIG});
        chk("mode", 32'h1, mode);
        s <= 12'ha5c; rx_slot <= 1'b1; auto_code <= 7'h2b;
        for (int k = 0; k < 8; k++) begin
            c = k[2:0];
            send({1'b1, 4'h9, c, c, c, ADDR_TEST});
            chk("route", 32'h1 << k, route);
            chk("mode", (k == 0), mode);
            chk("applied", {4'h9, c}, applied);
            chk("run", 32'h0, run);
            chk("frac", 32'h8, frac);
            chk("ovr", 32'h1, ovr);
            chk("tune", {4'h9, c}, tune);
            chk("dsel", c, dsel);
            for (int p = 0; p < 2; p++) begin
                @(posedge clk);
                s <= ~s;
                repeat (2) @(posedge clk);
                pt = {1'b0, s[9], 1'b0, s[6], 1'b0, s[3], 1'b0, s[0]};
                dt = {s[11], s[10], s[8], s[7], s[5], s[4], s[2], s[1]};
                chk("pa pin", pt[c], pa);
                chk("data pin", dt[c], dat);
            end
        end
        send({1'b0, 7'h11, 3'h0, 3'h0, ADDR_TEST});
        chk("applied", 32'h2b, applied);
        chk("run", 32'h1, run);
        chk("ovr", 32'h0, ovr);
        rx_slot <= 1'b0;
        repeat (3) @(posedge clk);
        chk("run", 32'h0, run);
        // 5760 MHz channel: fraction 7, integer 224; the second send arrives while busy
        wr(HREG_SEND, {16'h0, 10'h0e0, 4'h7, ADDR_CHANNEL}, r);
        send({10'h111, 4'h1, ADDR_CHANNEL});
        rd(HREG_STATUS, d, r);
        chk("busy reject", 32'h1, d[ST_REJECT_BIT]);
        chk("ncode", 32'h0e0, ncode);
        chk("frac", 32'h7, frac);
        // frequency scaled by 36/9.216 keeps the check in integers
        chk("freq", 32'd22500, 32'd18432 + 32'd18 * ncode + 32'd2 * (frac + 32'd11));
        close_out();
    end
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        close_out();
    end
endmodule
